// [logic/dcf_map.svh]
// Constants for the FIFO port controller: sizes, field positions, offsets
// Assumes inclusion by bare name from the design files; definitions only
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH

`define DCF_DATA_W     72
`define DCF_HALF_W     36
`define DCF_QUART_W    18
`define DCF_DEPTH      512
`define DCF_ADDR_W     9
`define DCF_CNT_W      10
`define DCF_OFF_W      9
`define DCF_PARITY_BIT 8
`define DCF_SYNC_W     15

// Default {full offset, empty offset} pairs, indexed {sel_high,sel_low,load}
`define DCF_DEF_OFF0   18'h00e07
`define DCF_DEF_OFF1   18'h01e0f
`define DCF_DEF_OFF2   18'h03e1f
`define DCF_DEF_OFF3   18'h07e3f
`define DCF_DEF_OFF4   18'h0fe7f
`define DCF_DEF_OFF5   18'h1feff
`define DCF_DEF_OFF6   18'h00603
`define DCF_DEF_OFF7   18'h00201

`endif

// [logic/dcf_pkg.sv]
// Types of the FIFO port controller; its memory uses none of them
// Assumes the constants header is included where sizes are needed
package dcf_pkg;

   typedef enum logic [1:0] {DCF_W72, DCF_W36, DCF_W18} dcf_width_t;

   typedef struct packed {
      dcf_width_t wr_width;
      dcf_width_t rd_width;
      logic       little_endian;
      logic       normal_retransmit;
      logic       sync_flags;
      logic       interspersed;
      logic       serial_prog;
      logic       fall_through;
   } dcf_mode_t;

endpackage : dcf_pkg

// [logic/dcf_mem.sv]
// Word memory of the FIFO: one write port, one read port
// Assumes a single clock; read data appear one edge after the request
`timescale 1ns/1ps
`include "dcf_map.svh"
module dcf_mem (
   // Clock
   input  wire logic                       clk,
   // Write port
   input  wire logic                       wr_en,
   input  wire logic [`DCF_ADDR_W-1:0]     wr_addr,
   input  wire logic [`DCF_DATA_W-1:0]     wr_data,
   // Read port
   input  wire logic                       rd_en,
   input  wire logic [`DCF_ADDR_W-1:0]     rd_addr,
   output logic      [`DCF_DATA_W-1:0]     rd_data
);

   typedef struct packed {
      logic [`DCF_DATA_W-1:0] rd_data;
   } dcf_mem_st_t;

   logic [`DCF_DATA_W-1:0] mem [0:`DCF_DEPTH-1];
   dcf_mem_st_t            s_r;
   dcf_mem_st_t            s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (rd_en) begin
         s_nxt.rd_data = mem[rd_addr];
      end
   end

   // Memory is not reset; contents are only read after being written
   always_ff @(posedge clk) begin
      s_r <= s_nxt;
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data = s_r.rd_data;

endmodule : dcf_mem

// [logic/dcf_port_ctrl.sv]
// FIFO port controller: reset straps, bus matching, offsets, flags
// Assumes writer and reader logic on clk; straps, resets and the serial
// load pins come from outside and are synchronised here
`timescale 1ns/1ps
`include "dcf_map.svh"
module dcf_port_ctrl (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    resetn,
   // Reset pins and mode straps
   input  wire logic                    master_reset_n,
   input  wire logic                    partial_reset_n,
   input  wire logic                    bus_matching_select,
   input  wire logic                    input_width_select,
   input  wire logic                    output_width_select,
   input  wire logic                    endian_order_select,
   input  wire logic                    retransmit_latency_select,
   input  wire logic                    flag_timing_select,
   input  wire logic                    parity_position_select,
   input  wire logic                    default_offset_sel_low,
   input  wire logic                    default_offset_sel_high,
   input  wire logic                    fall_through_select,
   // Offset load and serial programming
   input  wire logic                    offset_load_n,
   input  wire logic                    serial_clock,
   input  wire logic                    serial_load_enable_n,
   // Write side
   input  wire logic                    write_enable_n,
   input  wire logic [`DCF_DATA_W-1:0]  write_data,
   output logic                         write_status_n,
   // Read side
   input  wire logic                    read_enable_n,
   input  wire logic                    read_chip_select_n,
   input  wire logic                    output_enable_n,
   output logic      [`DCF_DATA_W-1:0]  read_data,
   output logic                         read_data_oe_n,
   output logic                         read_status,
   // Programmable flags and latched modes
   output logic                         almost_empty_flag_n,
   output logic                         almost_full_flag_n,
   output logic                         retransmit_normal,
   output logic                         flags_synchronous
);

   // ----------------------------------------------------------------
   // Synchroniser bit positions
   // ----------------------------------------------------------------
   localparam int SY_MRS = 14;
   localparam int SY_PRS = 13;
   localparam int SY_BM  = 12;
   localparam int SY_IW  = 11;
   localparam int SY_OW  = 10;
   localparam int SY_BE  = 9;
   localparam int SY_RM  = 8;
   localparam int SY_PFM = 7;
   localparam int SY_IP  = 6;
   localparam int SY_FSH = 5;
   localparam int SY_FSL = 4;
   localparam int SY_LD  = 3;
   localparam int SY_SI  = 2;
   localparam int SY_SCK = 1;
   localparam int SY_SEN = 0;

   typedef struct packed {
      logic [`DCF_SYNC_W-1:0] sync1;
      logic [`DCF_SYNC_W-1:0] sync2;
      logic                   sclk_prev;
      dcf_pkg::dcf_mode_t     mode;
      logic [`DCF_OFF_W-1:0]  off_empty;
      logic [`DCF_OFF_W-1:0]  off_full;
      logic                   off_wsel;
      logic                   off_rsel;
      logic [`DCF_DATA_W-1:0] acc;
      logic [1:0]             wr_piece;
      logic [`DCF_DATA_W-1:0] buf0;
      logic [`DCF_DATA_W-1:0] buf1;
      logic [1:0]             buf_cnt;
      logic [`DCF_ADDR_W-1:0] wr_ptr;
      logic [`DCF_ADDR_W-1:0] rd_ptr;
      logic [`DCF_CNT_W-1:0]  count;
      logic                   rd_pend;
      logic [`DCF_DATA_W-1:0] hold;
      logic                   hold_valid;
      logic [1:0]             rd_piece;
      logic [`DCF_DATA_W-1:0] q;
      logic                   q_valid;
      logic                   rcs_gate;
      logic                   wr_flag_n;
      logic                   rd_flag;
      logic                   ae_n;
      logic                   af_n;
   } dcf_st_t;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] dcf_last(input dcf_pkg::dcf_width_t w);
      case (w)
         dcf_pkg::DCF_W36: dcf_last = 2'h1;
         dcf_pkg::DCF_W18: dcf_last = 2'h3;
         default:          dcf_last = 2'h0;
      endcase
   endfunction : dcf_last

   function automatic logic [1:0] dcf_lane(input logic [1:0] idx,
                                           input logic [1:0] last,
                                           input logic       little);
      dcf_lane = little ? idx : last - idx;
   endfunction : dcf_lane

   function automatic logic [6:0] dcf_shift(input logic [1:0] pos,
                                            input dcf_pkg::dcf_width_t w);
      case (w)
         dcf_pkg::DCF_W36: dcf_shift = 7'({5'h0, pos}) * 7'(`DCF_HALF_W);
         dcf_pkg::DCF_W18: dcf_shift = 7'({5'h0, pos}) * 7'(`DCF_QUART_W);
         default:          dcf_shift = 7'h00;
      endcase
   endfunction : dcf_shift

   function automatic logic [`DCF_DATA_W-1:0] dcf_mask(
         input dcf_pkg::dcf_width_t w);
      case (w)
         dcf_pkg::DCF_W36: dcf_mask = {`DCF_DATA_W{1'b1}} >> `DCF_HALF_W;
         dcf_pkg::DCF_W18: dcf_mask = {`DCF_DATA_W{1'b1}} >>
                                      (`DCF_DATA_W - `DCF_QUART_W);
         default:          dcf_mask = {`DCF_DATA_W{1'b1}};
      endcase
   endfunction : dcf_mask

   function automatic logic [`DCF_DATA_W-1:0] dcf_place(
         input logic [`DCF_DATA_W-1:0] acc,
         input logic [`DCF_DATA_W-1:0] d,
         input logic [1:0]             pos,
         input dcf_pkg::dcf_width_t    w);
      logic [`DCF_DATA_W-1:0] m;
      logic [6:0]             sh;
      m  = dcf_mask(w);
      sh = dcf_shift(pos, w);
      dcf_place = (acc & ~(m << sh)) | ((d & m) << sh);
   endfunction : dcf_place

   function automatic logic [`DCF_DATA_W-1:0] dcf_extract(
         input logic [`DCF_DATA_W-1:0] word,
         input logic [1:0]             pos,
         input dcf_pkg::dcf_width_t    w);
      dcf_extract = (word >> dcf_shift(pos, w)) & dcf_mask(w);
   endfunction : dcf_extract

   function automatic logic [`DCF_OFF_W-1:0] dcf_strip(
         input logic [`DCF_DATA_W-1:0] d,
         input logic                   ip);
      dcf_strip = ip ? {d[`DCF_PARITY_BIT+1], d[`DCF_PARITY_BIT-1:0]}
                     : d[`DCF_OFF_W-1:0];
   endfunction : dcf_strip

   function automatic logic [2*`DCF_OFF_W-1:0] dcf_default(
         input logic [2:0] sel);
      case (sel)
         3'h0:    dcf_default = `DCF_DEF_OFF0;
         3'h1:    dcf_default = `DCF_DEF_OFF1;
         3'h2:    dcf_default = `DCF_DEF_OFF2;
         3'h3:    dcf_default = `DCF_DEF_OFF3;
         3'h4:    dcf_default = `DCF_DEF_OFF4;
         3'h5:    dcf_default = `DCF_DEF_OFF5;
         3'h6:    dcf_default = `DCF_DEF_OFF6;
         default: dcf_default = `DCF_DEF_OFF7;
      endcase
   endfunction : dcf_default

   // ----------------------------------------------------------------
   // State and memory
   // ----------------------------------------------------------------
   dcf_st_t                s_r;
   dcf_st_t                s_nxt;
   logic [`DCF_DATA_W-1:0] mem_q;
   logic                   mem_wr;
   logic                   mem_rd;
   logic [`DCF_SYNC_W-1:0] pins;
   logic                   in_master;
   logic                   in_reset;

   assign pins = {master_reset_n, partial_reset_n, bus_matching_select,
                  input_width_select, output_width_select,
                  endian_order_select, retransmit_latency_select,
                  flag_timing_select, parity_position_select,
                  default_offset_sel_high, default_offset_sel_low,
                  offset_load_n, fall_through_select, serial_clock,
                  serial_load_enable_n};

   assign in_master = ~s_r.sync2[SY_MRS];
   assign in_reset  = in_master | ~s_r.sync2[SY_PRS];

   // Drain the buffer into memory while there is room
   assign mem_wr = (s_r.buf_cnt != 2'h0) &&
                   (s_r.count != `DCF_CNT_W'(`DCF_DEPTH)) && !in_reset;
   // Prefetch one long word whenever the holding stage is free
   assign mem_rd = !s_r.hold_valid && !s_r.rd_pend &&
                   (s_r.count != '0) && !in_reset;

   dcf_mem u_mem (
      .clk     (clk),
      .wr_en   (mem_wr),
      .wr_addr (s_r.wr_ptr),
      .wr_data (s_r.buf0),
      .rd_en   (mem_rd),
      .rd_addr (s_r.rd_ptr),
      .rd_data (mem_q)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic                   wr_req;
      logic                   rd_req;
      logic                   off_mode;
      logic                   room;
      logic                   push;
      logic                   take;
      logic [1:0]             wlast;
      logic [1:0]             rlast;
      logic [`DCF_DATA_W-1:0] word;
      logic [`DCF_CNT_W-1:0]  cnt_f;
      logic [`DCF_CNT_W-1:0]  free;
      s_nxt    = s_r;
      take     = 1'b0;
      cnt_f    = '0;
      free     = '0;
      // Pins pass two flops before other logic reads them, except offset_load_n, which off_mode reads directly
      s_nxt.sync1     = pins;
      s_nxt.sync2     = s_r.sync1;
      s_nxt.sclk_prev = s_r.sync2[SY_SCK];
      off_mode = !offset_load_n;
      wr_req   = !write_enable_n && !in_reset;
      rd_req   = !read_enable_n && !read_chip_select_n && !in_reset;
      room     = s_r.buf_cnt != 2'h2;
      wlast    = dcf_last(s_r.mode.wr_width);
      rlast    = dcf_last(s_r.mode.rd_width);
      push     = 1'b0;
      word     = dcf_place(s_r.acc, write_data,
                           dcf_lane(s_r.wr_piece, wlast,
                                    s_r.mode.little_endian),
                           s_r.mode.wr_width);
      s_nxt.rcs_gate = read_chip_select_n;

      if (wr_req && off_mode && !s_r.mode.serial_prog) begin
         if (s_r.off_wsel) begin
            s_nxt.off_full = dcf_strip(write_data, s_r.mode.interspersed);
         end else begin
            s_nxt.off_empty = dcf_strip(write_data, s_r.mode.interspersed);
         end
         s_nxt.off_wsel = !s_r.off_wsel;
      end

      if (wr_req && !off_mode && room) begin
         if (s_r.wr_piece == wlast) begin
            push           = 1'b1;
            s_nxt.wr_piece = 2'h0;
            s_nxt.acc      = '0;
         end else begin
            s_nxt.wr_piece = s_r.wr_piece + 2'h1;
            s_nxt.acc      = word;
         end
      end

      // Two-entry buffer: a stalled memory side holds the writer off
      if (mem_wr) begin
         s_nxt.buf0    = s_r.buf1;
         s_nxt.buf_cnt = s_r.buf_cnt - 2'h1;
         s_nxt.wr_ptr  = s_r.wr_ptr + `DCF_ADDR_W'(1);
      end
      if (push) begin
         if (s_nxt.buf_cnt == 2'h0) begin
            s_nxt.buf0 = word;
         end else begin
            s_nxt.buf1 = word;
         end
         s_nxt.buf_cnt = s_nxt.buf_cnt + 2'h1;
      end

      // Memory read pipeline into the holding stage
      s_nxt.rd_pend = mem_rd;
      if (mem_rd) begin
         s_nxt.rd_ptr = s_r.rd_ptr + `DCF_ADDR_W'(1);
      end
      if (s_r.rd_pend) begin
         s_nxt.hold       = mem_q;
         s_nxt.hold_valid = 1'b1;
         s_nxt.rd_piece   = 2'h0;
      end
      s_nxt.count = s_r.count + `DCF_CNT_W'(mem_wr) - `DCF_CNT_W'(mem_rd);

      if (rd_req && off_mode) begin
         s_nxt.q = `DCF_DATA_W'(s_r.off_rsel ? s_r.off_full
                                             : s_r.off_empty);
         s_nxt.off_rsel = !s_r.off_rsel;
      end

      // data read; fall-through refills the output unasked
      take = s_r.hold_valid && !off_mode &&
             (s_r.mode.fall_through ? (!s_r.q_valid || rd_req) : rd_req);
      if (take) begin
         s_nxt.q = dcf_extract(s_r.hold,
                               dcf_lane(s_r.rd_piece, rlast,
                                        s_r.mode.little_endian),
                               s_r.mode.rd_width);
         s_nxt.q_valid = 1'b1;
         if (s_r.rd_piece == rlast) begin
            s_nxt.hold_valid = 1'b0;
            s_nxt.rd_piece   = 2'h0;
         end else begin
            s_nxt.rd_piece = s_r.rd_piece + 2'h1;
         end
      end else if (rd_req && !off_mode) begin
         s_nxt.q_valid = 1'b0;
      end

      if (!in_master && s_r.mode.serial_prog && !s_r.sync2[SY_SEN] &&
          s_r.sync2[SY_SCK] && !s_r.sclk_prev) begin
         {s_nxt.off_full, s_nxt.off_empty} =
            {s_r.off_full[`DCF_OFF_W-2:0], s_r.off_empty,
             s_r.sync2[SY_SI]};
      end

      // both resets clear the data path
      if (in_reset) begin
         s_nxt.acc        = '0;
         s_nxt.wr_piece   = 2'h0;
         s_nxt.buf_cnt    = 2'h0;
         s_nxt.wr_ptr     = '0;
         s_nxt.rd_ptr     = '0;
         s_nxt.count      = '0;
         s_nxt.rd_pend    = 1'b0;
         s_nxt.hold_valid = 1'b0;
         s_nxt.rd_piece   = 2'h0;
         s_nxt.q          = '0;
         s_nxt.q_valid    = 1'b0;
         s_nxt.off_wsel   = 1'b0;
         s_nxt.off_rsel   = 1'b0;
      end

      if (in_master) begin
         s_nxt.mode.wr_width = dcf_pkg::DCF_W72;
         s_nxt.mode.rd_width = dcf_pkg::DCF_W72;
         if (s_r.sync2[SY_BM] && s_r.sync2[SY_IW]) begin
            s_nxt.mode.wr_width = s_r.sync2[SY_OW] ? dcf_pkg::DCF_W18
                                                   : dcf_pkg::DCF_W36;
         end else if (s_r.sync2[SY_BM]) begin
            s_nxt.mode.rd_width = s_r.sync2[SY_OW] ? dcf_pkg::DCF_W18
                                                   : dcf_pkg::DCF_W36;
         end
         s_nxt.mode.little_endian     = s_r.sync2[SY_BE];
         s_nxt.mode.normal_retransmit = s_r.sync2[SY_RM];
         s_nxt.mode.sync_flags        = s_r.sync2[SY_PFM];
         s_nxt.mode.interspersed      = s_r.sync2[SY_IP];
         s_nxt.mode.serial_prog       = s_r.sync2[SY_LD];
         s_nxt.mode.fall_through      = s_r.sync2[SY_SI];
         {s_nxt.off_full, s_nxt.off_empty} =
            dcf_default({s_r.sync2[SY_FSH], s_r.sync2[SY_FSL],
                         s_r.sync2[SY_LD]});
      end

      s_nxt.wr_flag_n = s_r.mode.fall_through ? (s_nxt.buf_cnt == 2'h2)
                                              : (s_nxt.buf_cnt != 2'h2);
      s_nxt.rd_flag = s_r.mode.fall_through ? s_nxt.q_valid
                                            : s_nxt.hold_valid;
      // synchronous flags trail by one edge
      cnt_f = s_r.mode.sync_flags ? s_r.count : s_nxt.count;
      free  = `DCF_CNT_W'(`DCF_DEPTH) - cnt_f;
      s_nxt.ae_n = !(cnt_f < `DCF_CNT_W'(s_r.off_empty));
      s_nxt.af_n = !(free <= `DCF_CNT_W'(s_r.off_full));
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign write_status_n      = s_r.wr_flag_n;
   assign read_data           = s_r.q;
   assign read_status         = s_r.rd_flag;
   assign almost_empty_flag_n = s_r.ae_n;
   assign almost_full_flag_n  = s_r.af_n;
   assign retransmit_normal   = s_r.mode.normal_retransmit;
   assign flags_synchronous   = s_r.mode.sync_flags;
   // output enable is combinational, not clocked
   assign read_data_oe_n = output_enable_n | (!in_reset & s_r.rcs_gate);

endmodule : dcf_port_ctrl

// [bench/dcf_far_side.sv]
// Far-side writer and reader logic model of the port controller
// Assumes the bench paces it with go and chip-select controls on clk
`timescale 1ns/1ps
module dcf_far_side (
   // Controls from the bench
   input  wire logic wr_go,
   input  wire logic rd_go,
   input  wire logic cs_n,
   // Status from the controller
   input  wire logic write_status_n,
   input  wire logic read_status,
   // Requests to the controller
   output logic      write_enable_n,
   output logic      read_enable_n,
   output logic      read_chip_select_n
);
   assign write_enable_n = !(wr_go && write_status_n);
   // read only when a word waits
   assign read_enable_n = !(rd_go && read_status);
   assign read_chip_select_n = cs_n;
endmodule : dcf_far_side

// [bench/dcf_port_ctrl_assertions.sv]
// Checker of the FIFO port controller, bound into its top module
// Assumes one clock clk and resetn synchronous, active low
`timescale 1ns/1ps
module dcf_port_ctrl_chk (
   // Clock and resets
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        master_reset_n,
   input wire logic        partial_reset_n,
   // Straps
   input wire logic        retransmit_latency_select,
   input wire logic        fall_through_select,
   // Read side
   input wire logic        read_enable_n,
   input wire logic        read_chip_select_n,
   input wire logic        output_enable_n,
   input wire logic [71:0] read_data,
   input wire logic        read_data_oe_n,
   input wire logic        read_status,
   // Write side and modes
   input wire logic        write_status_n,
   input wire logic        retransmit_normal,
   input wire logic        flags_synchronous
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_oe_async; output_enable_n |-> read_data_oe_n; endproperty
   a_oe_async: assert property (p_oe_async)
      else $error("outputs driven with output enable off");
   property p_oe_reset;
      !master_reset_n [*3] |-> read_data_oe_n == output_enable_n;
   endproperty
   a_oe_reset: assert property (p_oe_reset)
      else $error("chip select acted during reset");
   // Chip select is registered, so it acts one edge late
   property p_rcs_gate;
      (master_reset_n && partial_reset_n) [*4] ##0 !output_enable_n
         |-> read_data_oe_n == $past(read_chip_select_n);
   endproperty
   a_rcs_gate: assert property (p_rcs_gate)
      else $error("drive state not from sampled chip select");
   property p_rm;
      (!master_reset_n && $stable(retransmit_latency_select)) [*7]
         |-> retransmit_normal == retransmit_latency_select;
   endproperty
   a_rm: assert property (p_rm)
      else $error("latency strap not taken");
   property p_mode_hold;
      master_reset_n [*8] |-> $stable(retransmit_normal)
         && $stable(flags_synchronous);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed outside master reset");
   property p_mrs_clear;
      !master_reset_n [*4] |-> read_data == 72'h0 && !read_status;
   endproperty
   a_mrs_clear: assert property (p_mrs_clear)
      else $error("master reset left output data");
   property p_prs_clear;
      !partial_reset_n [*4] |-> read_data == 72'h0 && !read_status
         && $stable(flags_synchronous);
   endproperty
   a_prs_clear: assert property (p_prs_clear)
      else $error("partial reset wrong");
   property p_ws_mode;
      (!master_reset_n && $stable(fall_through_select)) [*7]
         |-> write_status_n == !fall_through_select;
   endproperty
   a_ws_mode: assert property (p_ws_mode)
      else $error("write status wrong for timing mode");
   c_full: cover property (!write_status_n);
   c_take: cover property (!read_enable_n && !read_chip_select_n);
   c_cs_off: cover property (read_chip_select_n && read_data_oe_n);
endmodule : dcf_port_ctrl_chk
bind dcf_port_ctrl dcf_port_ctrl_chk u_dcf_port_ctrl_chk (.*);

// [bench/testbench.sv]
// Self-checking bench of the FIFO port controller, standard timing
// Assumes the far-side model and the bound checker compile alongside
`timescale 1ns/1ps
module testbench;
   logic        clk, resetn, master_reset_n, partial_reset_n;
   logic        bus_matching_select, input_width_select;
   logic        output_width_select, endian_order_select;
   logic        retransmit_latency_select, flag_timing_select;
   logic        parity_position_select, fall_through_select;
   logic        default_offset_sel_low, default_offset_sel_high;
   logic        offset_load_n, serial_clock, serial_load_enable_n;
   logic        write_enable_n, write_status_n, read_enable_n;
   logic        read_chip_select_n, output_enable_n, read_data_oe_n;
   logic        read_status, almost_empty_flag_n, almost_full_flag_n;
   logic        retransmit_normal, flags_synchronous, wr_go, rd_go, cs_n;
   logic [71:0] write_data, read_data, acc;
   logic [71:0] q[$];
   logic [1:0]  c;
   int          mismatches, checked, wd, ww, p, i, k, n;
   integer      seed = 32'haf82;
   dcf_port_ctrl u_dcf_port_ctrl (.*);
   dcf_far_side  u_dcf_far_side (.*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input logic [71:0] s, input logic [71:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task conclude;
      $display("Compared %0d, mismatched %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task lim(input int m);
      if (i >= m) begin
         mismatches++;
         conclude();
      end
   endtask : lim
   task mreset;
      master_reset_n            <= 1'b0;
      bus_matching_select       <= c != 2'h0;
      input_width_select        <= c == 2'h3;
      output_width_select       <= c == 2'h2;
      endian_order_select       <= c[1];
      offset_load_n             <= c[0];
      parity_position_select    <= c[1];
      retransmit_latency_select <= 1'($random(seed));
      flag_timing_select        <= 1'($random(seed));
      wd = (c == 2'h1) ? 36 : (c == 2'h2) ? 18 : 72;
      ww = (c == 2'h3) ? 36 : 72;
      repeat (8) @(posedge clk);
      master_reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      offset_load_n <= 1'b1;
      @(posedge clk);
      chk(retransmit_normal, retransmit_latency_select);
      chk(flags_synchronous, flag_timing_select);
   endtask : mreset
   // accepted pieces packed, each long word noted in read order
   always @(posedge clk) begin
      if (resetn && !write_enable_n && write_status_n) begin
         acc = acc | (write_data & ~({72{1'b1}} << ww))
                     << ((endian_order_select ? p : 72/ww-1-p) * ww);
         p++;
         if (p == 72 / ww) begin
            n = 72 / wd;
            for (k = 0; k < n; k++)
               q.push_back(acc >> ((endian_order_select ? k : n-1-k)
                  * wd) & ~({72{1'b1}} << wd));
            acc = '0;
            p   = 0;
         end
         write_data <= 72'({$random(seed), $random(seed), $random(seed)});
      end
   end
   always @(posedge clk) begin
      if (resetn && !read_enable_n && !read_chip_select_n && read_status) begin
         #1;
         if (q.size() == 0)
            chk(72'h1, 72'h0);
         else
            chk(read_data, q.pop_front());
      end
   end
   initial begin
      {resetn, master_reset_n, bus_matching_select, input_width_select,
         output_width_select, endian_order_select, flag_timing_select,
         retransmit_latency_select, parity_position_select, wr_go, rd_go,
         fall_through_select, default_offset_sel_low, serial_clock, cs_n,
         default_offset_sel_high, output_enable_n, write_data, acc} = '0;
      {partial_reset_n, offset_load_n, serial_load_enable_n} = 3'h7;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      for (int j = 0; j < 4; j++) begin
         c = 2'(j);
         mreset();
         // Reader stalled so the buffer and memory fill until refused
         wr_go <= 1'b1;
         for (i = 0; i < 1200 && write_status_n; i++)
            @(posedge clk);
         lim(1200);
         wr_go <= 1'b0;
         chk(72'(q.size() * wd >= 512 * 72), 72'h1);
         chk(almost_full_flag_n, 1'b0);
         chk(almost_empty_flag_n, 1'b1);
         for (i = 0; i < 20000 && q.size() != 0; i++) begin
            @(posedge clk);
            rd_go           <= 1'($random(seed));
            cs_n            <= ($random(seed) & 3) == 0;
            output_enable_n <= 1'($random(seed));
         end
         lim(20000);
         rd_go <= 1'b0;
         repeat (4) @(posedge clk);
         chk(read_status, 1'b0);
         chk(almost_empty_flag_n, 1'b0);
         chk(almost_full_flag_n, 1'b1);
         partial_reset_n <= 1'b0;
         repeat (5) @(posedge clk);
         partial_reset_n <= 1'b1;
         repeat (6) @(posedge clk);
         chk(retransmit_normal, retransmit_latency_select);
         $display("Config %0d done", j);
      end
      conclude();
   end
endmodule : testbench
